// >>> rtl/sfe_exc_ctrl.sv
/*
 * exception sequencing, control/status word, control register four bits,
 * identification leaf and x87 pin separation of the simd fp unit.
 * assumes inputs synchronous to clk_i and one instruction at a time.
 */
`timescale 1ns/1ps
// Operation
// - post pass ors, flags, repeats dispatch
// - complete only after post pass or post handler return
// - fault may fire twice per instruction
// - flag all; masked results wait completion
// - simd exceptions never drive error pin
// - simd handling ignores ignore-error pin
// - separate simd and x87 flags/masks
// - simd rounding only from own field
// - unmasking a set flag raises nothing
// - query leaf one: bits 25, 26
// - query leaf one: save/restore bit 24
// - reg four bit 9 readable
// - reg four bit 10 readable
// - unsupported instruction raises invalid opcode
// - save image carries writable mask
// - zero mask means no denormal zeroing
// - reserved bit write raises protection fault
// - no os fault support: invalid opcode
// - pre pass ors, flags, keeps operands
// - reset sets all six masks
module sfe_exc_ctrl
#(
	parameter int   LANES    = 4,
	parameter logic HAS_ONE  = 1'b1,
	parameter logic HAS_TWO  = 1'b1,
	parameter logic HAS_SAVE = 1'b1,
	parameter logic HAS_DAZ  = 1'b1
)
(
	input  wire logic                         clk_i,
	input  wire logic                         resetn_i,
	input  wire sfe_pkg::sfe_req_s            req_i,
	input  wire logic [LANES*sfe_pkg::SFE_NCOND-1:0] lane_cond_i,
	input  wire logic                         handler_ret_i,
	input  wire logic                         csr_wr_i,
	input  wire logic [31:0]                  csr_wdata_i,
	input  wire logic                         cr4_wr_i,
	input  wire logic [31:0]                  cr4_wdata_i,
	input  wire logic                         fp_emulation_i,
	input  wire logic                         native_fp_error_enable_i,
	input  wire logic                         ignore_numeric_error_pin_i,
	input  wire logic                         x87_error_i,
	input  wire logic                         query_i,
	input  wire logic [31:0]                  accumulator_reg_i,
	output sfe_pkg::sfe_fault_s               fault_o,
	output logic                              instr_done_o,
	output logic                              result_commit_o,
	output logic                              operand_hold_o,
	output logic                              busy_o,
	output logic [31:0]                       simd_control_status_o,
	output logic [1:0]                        simd_round_o,
	output logic [31:0]                       control_reg_four_o,
	output logic [31:0]                       feature_o,
	output logic [31:0]                       control_writable_mask_o,
	output logic                              fp_error_pin_o,
	output logic                              x87_fault_o
);
	import sfe_pkg::*;

	// ==========================================================
	// state
	typedef struct packed
	{
		sfe_state_e          st;
		logic [15:0]         csr;
		logic                os_save;
		logic                os_fault;
		logic [SFE_NCOND-1:0] cond;
		sfe_fault_s          flt;
		logic                done;
		logic                commit;
		logic                hold;
		logic                busy;
		logic [31:0]         feat;
		logic                fp_error_pin;
		logic                x87f;
	} sfe_regs_s;

	localparam logic [31:0] VALID = HAS_DAZ ? SFE_VALID_DAZ : SFE_VALID_NDAZ;

	sfe_regs_s            q, d;
	logic [SFE_NCOND-1:0] lane_or;
	logic [SFE_NCOND-1:0] set_v;
	logic [SFE_NCOND-1:0] unm_v;
	logic [SFE_NCOND-1:0] mask_v;
	logic [31:0]          feat_v;

	sfe_lane_or #(.LANES(LANES), .NCOND(SFE_NCOND)) u_or
	(
		.lane_cond_i (lane_cond_i),
		.cond_o      (lane_or)
	);

	// ==========================================================
	// next state
	always_comb
	begin
		d        = q;
		d.flt    = '0;
		d.done   = 1'b0;
		d.commit = 1'b0;
		set_v    = '0;
		unm_v    = '0;
		mask_v   = q.csr[SFE_MASK_LSB +: SFE_NCOND];
		feat_v   = '0;
		feat_v[SFE_FEAT_ONE]  = HAS_ONE;
		feat_v[SFE_FEAT_TWO]  = HAS_TWO;
		feat_v[SFE_FEAT_SAVE] = HAS_SAVE;
		case (q.st)
			SFE_IDLE:
			begin
				if (req_i.start)
				begin
					// emulation set also makes the opcode unusable
					if (!HAS_ONE || (req_i.is_two && !HAS_TWO) ||
						fp_emulation_i)
					begin
						d.flt.ud = 1'b1;
					end
					else
					begin
						d.cond = lane_or;
						d.hold = 1'b1;
						d.st   = SFE_PRE;
					end
				end
			end
			SFE_PRE:
			begin
				// only fresh conditions count, never old flags
				set_v = q.cond & SFE_PRE_SEL;
				unm_v = set_v & ~mask_v;
				d.st  = SFE_POST;
				if (|unm_v)
				begin
					if (q.os_fault)
					begin
						d.flt.xf = 1'b1;
						d.st     = SFE_PRE_WAIT;
					end
					else
					begin
						d.flt.ud = 1'b1;
						d.hold   = 1'b0;
						d.st     = SFE_IDLE;
					end
				end
			end
			SFE_PRE_WAIT:
			begin
				if (handler_ret_i)
				begin
					d.st = SFE_POST;
				end
			end
			SFE_POST:
			begin
				// handler may have changed masks, so use them as now
				set_v = q.cond & SFE_POST_SEL;
				unm_v = set_v & ~mask_v;
				d.st  = SFE_IDLE;
				d.hold = 1'b0;
				if (|unm_v)
				begin
					d.hold = 1'b1;
					if (q.os_fault)
					begin
						d.flt.xf = 1'b1;
						d.st     = SFE_POST_WAIT;
					end
					else
					begin
						d.flt.ud = 1'b1;
						d.hold   = 1'b0;
					end
				end
				else
				begin
					d.done   = 1'b1;
					d.commit = 1'b1;
				end
			end
			SFE_POST_WAIT:
			begin
				if (handler_ret_i)
				begin
					d.st     = SFE_IDLE;
					d.hold   = 1'b0;
					d.done   = 1'b1;
					d.commit = 1'b1;
				end
			end
			default:
			begin
				d.st   = SFE_IDLE;
				d.hold = 1'b0;
			end
		endcase

		if (csr_wr_i)
		begin
			if (|(csr_wdata_i & ~VALID))
			begin
				d.flt.gp = 1'b1;
			end
			else
			begin
				d.csr = csr_wdata_i[15:0];
			end
		end
		// hardware set wins over a clearing write
		d.csr[SFE_FLAG_LSB +: SFE_NCOND] =
			d.csr[SFE_FLAG_LSB +: SFE_NCOND] | set_v;

		if (cr4_wr_i)
		begin
			d.os_save  = cr4_wdata_i[SFE_OS_SAVE_BIT];
			d.os_fault = cr4_wdata_i[SFE_OS_FAULT_BIT];
		end
		if (query_i)
		begin
			d.feat = (accumulator_reg_i == SFE_QUERY_LEAF) ? feat_v : '0;
		end
		// x87 side only; simd events never reach these
		d.fp_error_pin = x87_error_i & ~native_fp_error_enable_i;
		d.x87f = x87_error_i & native_fp_error_enable_i &
			~ignore_numeric_error_pin_i;
		d.busy = d.st != SFE_IDLE;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			q     <= '0;
			q.st  <= SFE_IDLE;
			q.csr <= SFE_CSR_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	always_comb
	begin
		fault_o               = q.flt;
		instr_done_o          = q.done;
		result_commit_o       = q.commit;
		operand_hold_o        = q.hold;
		busy_o                = q.busy;
		simd_control_status_o = {16'h0000, q.csr};
		simd_round_o          = q.csr[SFE_RC_LSB +: 2];
		control_reg_four_o    = '0;
		control_reg_four_o[SFE_OS_SAVE_BIT]  = q.os_save;
		control_reg_four_o[SFE_OS_FAULT_BIT] = q.os_fault;
		feature_o             = q.feat;
		control_writable_mask_o = HAS_DAZ ? VALID
			: SFE_SAVE_NDAZ;
		fp_error_pin_o        = q.fp_error_pin;
		x87_fault_o           = q.x87f;
	end

	// ==========================================================
	// checks
	logic [1:0] xf_cnt_q;
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i || q.st == SFE_IDLE)
		begin
			xf_cnt_q <= 2'h0;
		end
		else if (d.flt.xf)
		begin
			xf_cnt_q <= xf_cnt_q + 2'h1;
		end
	end

	xf_twice_max_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		xf_cnt_q != 2'h3) else $error("more than two simd faults");
	done_after_ret_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		instr_done_o |-> $past(q.st) == SFE_POST ||
		($past(q.st) == SFE_POST_WAIT && $past(handler_ret_i)))
		else $error("completion without post pass or return");
	commit_with_done_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		result_commit_o |-> instr_done_o && !operand_hold_o)
		else $error("masked results released early");
	xf_needs_os_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fault_o.xf |-> $past(q.os_fault) && !fault_o.ud)
		else $error("simd fault without os support");
	fp_error_pin_x87_only_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		fp_error_pin_o |-> $past(x87_error_i) && !$past(native_fp_error_enable_i))
		else $error("error pin without x87 cause");
	flags_sticky_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		|($past(q.csr[5:0]) & ~q.csr[5:0]) |-> $past(csr_wr_i))
		else $error("flag cleared without write");
	gp_reserved_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		csr_wr_i && |(csr_wdata_i & ~VALID) |=> fault_o.gp &&
		simd_control_status_o[15:6] == $past(simd_control_status_o[15:6]))
		else $error("reserved write not refused");
	reset_masks_a: assert property (@(posedge clk_i)
		!resetn_i |=> simd_control_status_o[12:7] == 6'h3f)
		else $error("masks not set by reset");
	query_leaf_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		query_i && accumulator_reg_i == SFE_QUERY_LEAF |=>
		feature_o[SFE_FEAT_ONE] == HAS_ONE && feature_o[SFE_FEAT_TWO] == HAS_TWO
		&& feature_o[SFE_FEAT_SAVE] == HAS_SAVE)
		else $error("feature bits wrong");
	no_fault_on_unmask_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
		q.st == SFE_IDLE && !req_i.start |=> !fault_o.xf)
		else $error("fault without new occurrence");

	two_faults_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		xf_cnt_q == 2'h2 && instr_done_o);
	clean_done_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		req_i.start ##3 instr_done_o);
	ud_no_os_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
		fault_o.ud && busy_o == 1'b0 && !q.os_fault);

endmodule : sfe_exc_ctrl

// >>> rtl/sfe_lane_or.sv
/*
 * or-reduction of per-lane exception conditions into one vector.
 * assumes lane conditions are packed lane 0 in the low bits.
 */
`timescale 1ns/1ps
module sfe_lane_or
#(
	parameter int LANES = 4,
	parameter int NCOND = 6
)
(
	input  wire logic [LANES*NCOND-1:0] lane_cond_i,
	output logic      [NCOND-1:0]       cond_o
);

	// ==========================================================
	// reduction
	always_comb
	begin
		cond_o = '0;
		for (int l = 0; l < LANES; l++)
		begin
			cond_o = cond_o | lane_cond_i[l*NCOND +: NCOND];
		end
	end

endmodule : sfe_lane_or

// >>> rtl/sfe_pkg.sv
/*
 * shared constants and carrier types of the simd floating-point exception
 * control block. assumes one 200 mhz core clock and software as partner.
 */
package sfe_pkg;

	// ==========================================================
	// control/status word layout
	localparam int                 SFE_NCOND      = 6;
	localparam int                 SFE_FLAG_LSB   = 0;
	localparam int                 SFE_DAZ_BIT    = 6;
	localparam int                 SFE_MASK_LSB   = 7;
	localparam int                 SFE_RC_LSB     = 13;
	localparam int                 SFE_FTZ_BIT    = 15;
	localparam logic [15:0]        SFE_CSR_RESET  = 16'h1f80;
	localparam logic [31:0]        SFE_VALID_DAZ  = 32'h0000ffff;
	localparam logic [31:0]        SFE_VALID_NDAZ = 32'h0000ffbf;
	localparam logic [31:0]        SFE_SAVE_NDAZ  = 32'h00000000;
	// pre-computation: invalid, denormal, divide; post: ovf, unf, inexact
	localparam logic [SFE_NCOND-1:0] SFE_PRE_SEL  = 6'h07;
	localparam logic [SFE_NCOND-1:0] SFE_POST_SEL = 6'h38;

	// ==========================================================
	// control register four and identification leaf
	localparam int                 SFE_OS_SAVE_BIT  = 9;
	localparam int                 SFE_OS_FAULT_BIT = 10;
	localparam logic [31:0]        SFE_QUERY_LEAF   = 32'h00000001;
	localparam int                 SFE_FEAT_SAVE    = 24;
	localparam int                 SFE_FEAT_ONE     = 25;
	localparam int                 SFE_FEAT_TWO     = 26;
	localparam int                 SFE_SAVE_BYTES   = 512;
	localparam int                 SFE_SAVE_MASK_LO = 28;
	localparam int                 SFE_SAVE_MASK_HI = 31;

	// ==========================================================
	// carriers
	typedef enum logic [2:0]
	{
		SFE_IDLE      = 3'h0,
		SFE_PRE       = 3'h1,
		SFE_PRE_WAIT  = 3'h3,
		SFE_POST      = 3'h2,
		SFE_POST_WAIT = 3'h6
	} sfe_state_e;

	typedef struct packed
	{
		logic xf;
		logic ud;
		logic gp;
	} sfe_fault_s;

	typedef struct packed
	{
		logic start;
		logic is_two;
	} sfe_req_s;

endpackage : sfe_pkg

// >>> testbench/sfe_exc_ctrl_test.sv
/*
 * self-checking bench of the simd fp exception control block.
 * assumes the software handler model and the design package.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) n_checks++; \
	if ((got) !== (ex)) begin \
	$display("wrong value %s exp %h got %h", nm, ex, got); n_fail++; end
module sfe_exc_ctrl_test;
	import sfe_pkg::*;
	logic        clk_i, resetn_i, hret, csr_wr, cr4_wr, emu, ne, ign;
	logic        x87e, query, done, commit, hold, busy, fp_error_pin, x87f;
	sfe_req_s    req;
	sfe_fault_s  fault;
	logic [23:0] lanes;
	logic [31:0] csr_wd, cr4_wd, acc, csr, cr4, feat, wmask;
	logic [1:0]  rnd;
	int          n_fail, n_checks, nxf, nud, ngp, ndone, ncommit, nferr;

	// ==========================================================
	// design and software partner
	sfe_exc_ctrl DUT (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
		.lane_cond_i(lanes), .handler_ret_i(hret), .csr_wr_i(csr_wr),
		.csr_wdata_i(csr_wd), .cr4_wr_i(cr4_wr), .cr4_wdata_i(cr4_wd),
		.fp_emulation_i(emu), .native_fp_error_enable_i(ne),
		.ignore_numeric_error_pin_i(ign), .x87_error_i(x87e),
		.query_i(query), .accumulator_reg_i(acc), .fault_o(fault),
		.instr_done_o(done), .result_commit_o(commit),
		.operand_hold_o(hold), .busy_o(busy),
		.simd_control_status_o(csr), .simd_round_o(rnd),
		.control_reg_four_o(cr4), .feature_o(feat),
		.control_writable_mask_o(wmask), .fp_error_pin_o(fp_error_pin),
		.x87_fault_o(x87f));
	sfe_sw_model SW (.clk_i(clk_i), .xf_i(fault.xf), .handler_ret_o(hret));

	// ==========================================================
	// clock and pulse counters
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		if (fault.xf === 1'b1) nxf++;
		if (fault.ud === 1'b1) nud++;
		if (fault.gp === 1'b1) ngp++;
		if (done === 1'b1) ndone++;
		if (commit === 1'b1 && done === 1'b1) ncommit++;
		if (fp_error_pin === 1'b1) nferr++;
	end

	// ==========================================================
	// access tasks; all drive 1 ns after the edge
	task automatic clk1();
		@(posedge clk_i);
		#1;
	endtask : clk1
	task automatic finish_test();
		if (n_fail == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic wcsr(input logic [31:0] v);
		csr_wr = 1'b1;
		csr_wd = v;
		clk1();
		csr_wr = 1'b0;
		clk1();
	endtask : wcsr
	task automatic wcr4(input logic [31:0] v);
		cr4_wr = 1'b1;
		cr4_wd = v;
		clk1();
		cr4_wr = 1'b0;
		clk1();
	endtask : wcr4
	task automatic ask(input logic [31:0] leaf, input logic [31:0] ex);
		acc = leaf;
		query = 1'b1;
		clk1();
		query = 1'b0;
		clk1();
		`CHK("feature", ex, feat)
	endtask : ask
	// conditions go in lane 1 so the lane or is exercised
	task automatic run(input logic [5:0] c, input int xf, ud, dn);
		int i;
		nxf = 0;
		nud = 0;
		ndone = 0;
		ncommit = 0;
		nferr = 0;
		req.start = 1'b1;
		lanes = {12'h000, c, 6'h00};
		clk1();
		req.start = 1'b0;
		lanes = 24'h000000;
		`CHK("hold", !emu, hold)
		`CHK("busy", !emu, busy)
		i = 0;
		do
		begin
			clk1();
			i++;
		end while ((busy !== 1'b0 || i < 4) && i < 80);
		if (i >= 80)
		begin
			n_fail++;
			finish_test();
		end
		// done pulse is counted one edge after busy falls
		clk1();
		`CHK("xf", xf, nxf)
		`CHK("ud", ud, nud)
		`CHK("done", dn, ndone)
		`CHK("commit", dn, ncommit)
		`CHK("hold", 1'b0, hold)
	endtask : run

	// ==========================================================
	// sequence
	initial
	begin
		resetn_i = 1'b0;
		req = '0;
		lanes = '0;
		{csr_wr, cr4_wr, emu, ign, x87e, query} = '0;
		{csr_wd, cr4_wd, acc} = '0;
		ne = 1'b1;
		repeat (6) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		`CHK("csr", 32'h00001f80, csr)
		`CHK("wmask", 32'h0000ffff, wmask)
		`CHK("wmask6", 1'b1, wmask[6])
		ask(32'h00000001, 32'h07000000);
		ask(32'h00000002, 32'h00000000);
		wcr4(32'hffffffff);
		`CHK("cr4", 32'h00000600, cr4)
		run(6'h3f, 0, 0, 1);
		`CHK("csr", 32'h00001fbf, csr)
		req.is_two = 1'b1;
		run(6'h00, 0, 0, 1);
		req.is_two = 1'b0;
		`CHK("csr", 32'h00001fbf, csr)
		nxf = 0;
		wcsr(32'h0000003f);
		repeat (6) clk1();
		`CHK("xf", 0, nxf)
		ne = 1'b0;
		ign = 1'b1;
		run(6'h09, 2, 0, 1);
		`CHK("fp_error_pin", 0, nferr)
		`CHK("csr", 32'h0000003f, csr)
		ne = 1'b1;
		ign = 1'b0;
		wcsr(32'h00001b80);
		run(6'h0a, 1, 0, 1);
		`CHK("csr", 32'h00001b8a, csr)
		wcsr(32'h00006000);
		`CHK("round", 2'b11, rnd)
		ngp = 0;
		wcsr(32'h00016000);
		`CHK("gp", 1, ngp)
		`CHK("csr", 32'h00006000, csr)
		wcsr(32'h00000000);
		wcr4(32'h00000200);
		`CHK("cr4", 32'h00000200, cr4)
		run(6'h01, 0, 1, 0);
		`CHK("csr", 32'h00000001, csr)
		wcr4(32'h00000600);
		emu = 1'b1;
		run(6'h00, 0, 1, 0);
		emu = 1'b0;
		x87e = 1'b1;
		repeat (2) clk1();
		`CHK("x87f", 1'b1, x87f)
		`CHK("fp_error_pin", 1'b0, fp_error_pin)
		`CHK("csr", 32'h00000001, csr)
		ne = 1'b0;
		repeat (2) clk1();
		`CHK("fp_error_pin", 1'b1, fp_error_pin)
		finish_test();
	end
endmodule : sfe_exc_ctrl_test

// >>> testbench/sfe_sw_model.sv
/*
 * software side of the simd fp unit: a fault handler that returns
 * after a fixed delay. assumes fault pulses are registered, one cycle.
 */
`timescale 1ns/1ps
module sfe_sw_model
#(
	parameter int DELAY = 4
)
(
	input  wire logic clk_i,
	input  wire logic xf_i,
	output logic      handler_ret_o
);
	// ==========================================================
	// handler: slow on purpose so the unit must wait
	initial
	begin
		handler_ret_o = 1'b0;
		forever
		begin
			@(posedge clk_i);
			if (xf_i === 1'b1)
			begin
				repeat (DELAY) @(posedge clk_i);
				#1 handler_ret_o = 1'b1;
				@(posedge clk_i);
				#1 handler_ret_o = 1'b0;
			end
		end
	end
endmodule : sfe_sw_model
